// [bench/burst_source.sv]
// Purpose : framer and keystream source model facing the xor block
// Assumes : beats go out in index order, one per cycle unless stalled
// Notes   : idle lines toggle so a stale bit never passes for a beat
`timescale 1ns/10ps

module burst_source
(
    input  wire logic        MCLK,      // system clock
    input  wire logic        GO,        // request one segment
    input  wire logic [12:0] LEN,       // beats in the segment
    input  wire logic        GAP,       // 1 = stall every third cycle
    output logic             START,     // segment start pulse
    output logic             KS_VALID,  // beat present
    output logic             KS_BIT,    // keystream bit
    output logic             DIN_BIT    // paired data bit
);
    // ----------------------------------------------------------------
    // fixed bit patterns, also read by the bench
    // ----------------------------------------------------------------
    function automatic logic ks_of(input int k);
        return k[0] ^ k[2] ^ k[5] ^ k[9];
    endfunction
    function automatic logic din_of(input int k);
        return k[1] ^ k[4] ^ k[7];
    endfunction

    int   idx;  // next beat index
    logic run;  // segment being sent
    int   ph;   // stall phase

    initial
    begin
        {START, KS_VALID, KS_BIT, DIN_BIT, run, idx, ph} = '0;
    end

    // ----------------------------------------------------------------
    // start pulse, then beats; no beat in the start cycle
    // ----------------------------------------------------------------
    always @(posedge MCLK)
    begin
        START <= GO;
        ph = (ph + 1) % 3;
        if (GO)
        begin
            {run, idx} = {1'b1, 32'h0};
            KS_VALID <= 1'b0;
        end
        else if (run && idx < int'(LEN) && !(GAP && ph == 0))
        begin
            KS_VALID <= 1'b1;
            KS_BIT   <= ks_of(idx);
            DIN_BIT  <= din_of(idx);
            idx = idx + 1;
        end
        else
        begin
            // idle or stalled: inverse of last value
            run      = run && idx < int'(LEN);
            KS_VALID <= 1'b0;
            KS_BIT   <= ~KS_BIT;
            DIN_BIT  <= ~DIN_BIT;
        end
    end
endmodule

// [bench/tb.sv]
// Purpose : self-checking bench for the keystream xor mapper
// Assumes : bench drives at the rising edge, outputs checked a cycle on
// Notes   : expected stream built from mapping tables kept here
`timescale 1ns/10ps

module tb;
    import bfield_ks_pkg::*;

    logic        MCLK, ARST_N, WR_STB, RD_STB, GO, GAP;
    logic [7:0]  ADDR;
    logic [31:0] WR_DATA, RD_DATA;
    logic [12:0] LEN;
    logic        START, KS_VALID, KS_BIT, DIN_BIT;
    logic        OUT_VALID, OUT_BIT, OUT_FIELD_B, BUSY, DONE;
    int          errors, checks;
    logic [1:0]  exp_q [$];  // {field, bit} in output order
    logic [31:0] rv;         // read result
    // data bits per slot row and level column
    int sgl [5][5] = '{'{768, 1568, 2368, 3168, 4768}, '{304, 608, 928, 1248, 1888},
                       '{0, 0, 0, 0, 0}, '{608, 1248, 1888, 2528, 3808},
                       '{640, 1312, 1984, 2556, 4000}};
    int sub [5]  = '{10, 4, 1, 8, 8};        // subfields at lowest level
    int raw [5]  = '{800, 320, 80, 640, 672}; // raw bits at lowest level
    int mult [5] = '{1, 2, 3, 4, 6};

    bfield_ks_xor bfield_ks_xor_i (.MCLK(MCLK), .ARST_N(ARST_N), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .START(START), .KS_VALID(KS_VALID),
        .KS_BIT(KS_BIT), .DIN_BIT(DIN_BIT), .OUT_VALID(OUT_VALID), .OUT_BIT(OUT_BIT),
        .OUT_FIELD_B(OUT_FIELD_B), .BUSY(BUSY), .DONE(DONE));
    burst_source burst_source_i (.MCLK(MCLK), .GO(GO), .LEN(LEN), .GAP(GAP), .START(START),
        .KS_VALID(KS_VALID), .KS_BIT(KS_BIT), .DIN_BIT(DIN_BIT));

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        {ADDR, WR_DATA, WR_STB} <= {a, d, 1'b1};
        @(posedge MCLK);
        WR_STB <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge MCLK);
        {ADDR, RD_STB} <= {a, 1'b1};
        @(posedge MCLK);
        RD_STB <= 1'b0;
        #1 rv = RD_DATA;
    endtask
    function automatic int lvl(input logic [2:0] c);
        case (c)
            CFG_1A, CFG_1B: return 0;
            CFG_2, CFG_4A:  return 1;
            CFG_3, CFG_4B:  return 2;
            CFG_5:          return 3;
            default:        return 4;
        endcase
    endfunction

    // predict the mapped stream, then send one whole segment
    task automatic run_seg(input logic [2:0] c, s, input logic m, t, g);
        int sp, lv, len, r, n;
        sp  = (c == CFG_4A) ? 80 : (c == CFG_4B) ? 120 : 40;
        lv  = lvl(c);
        len = sp + raw[s] * mult[lv];
        exp_q.delete();
        for (int k = 0; k < len; k++)
        begin
            r = k - sp;
            if (k < sp ? t : (m ? (r % 80 < 64 && r / 80 < sub[s] * mult[lv]) : r < sgl[s][lv]))
                exp_q.push_back({k >= sp, burst_source_i.ks_of(k) ^ burst_source_i.din_of(k)});
        end
        wr(CTRL_OFFSET, {22'h0, t, m, 1'b0, s, 1'b0, c});
        {GO, GAP, LEN} <= {1'b1, g, 13'(len)};
        @(posedge MCLK);
        GO <= 1'b0;
        n = 0;
        while (DONE !== 1'b1 && n < 3 * len + 50)
        begin
            @(posedge MCLK);
            #1 n++;
        end
        check(n < 3 * len + 50, "segment never completed");
        @(posedge MCLK);
        #1 check(exp_q.size() == 0 && BUSY === 1'b0, "mapped bit count wrong");
        rd(STATUS_OFFSET);
        check(rv[28:16] === 13'(len) && rv[13:1] === 13'(len) && rv[0] === 1'b0, "status wrong");
    endtask

    // every mapped bit, in order, with its field flag
    always @(posedge MCLK)
        if (OUT_VALID === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(1'b0, "unexpected output bit");
            else
                check({OUT_FIELD_B, OUT_BIT} === exp_q.pop_front(), "output bit wrong");
        end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(CTRL_OFFSET);
        check(rv === CTRL_RESET, "control reset value");
        wr(STATUS_OFFSET, 32'hFFFF_FFFF);
        rd(CTRL_OFFSET);
        check(rv === CTRL_RESET, "status write altered control");
        rd(8'h08);
        check(rv === 32'h0000_0000, "unmapped read not zero");
        rd(STATUS_OFFSET);
        check(rv[0] === 1'b0, "busy while idle");
        wr(CTRL_OFFSET, 32'h0000_0375);
        rd(CTRL_OFFSET);
        check(rv === 32'h0000_0375, "control readback wrong");
    endtask
    task automatic t_single();
        for (int c = 0; c < 8; c++)
            run_seg(3'(c), SLOT_FULL, 1'b0, 1'b1, 1'b0);
        run_seg(CFG_1A, SLOT_DOUBLE, 1'b0, 1'b0, 1'b1);
        run_seg(CFG_6, SLOT_DOUBLE, 1'b0, 1'b1, 1'b0);
        run_seg(CFG_5, SLOT_LONG640, 1'b0, 1'b0, 1'b0);
        run_seg(CFG_5, SLOT_LONG672, 1'b0, 1'b1, 1'b0);
        run_seg(CFG_6, SLOT_LONG672, 1'b0, 1'b0, 1'b1);
        run_seg(CFG_2, SLOT_HALF, 1'b0, 1'b1, 1'b0);
    endtask
    task automatic t_multi();
        for (int c = 0; c < 8; c++)
            run_seg(3'(c), SLOT_HALF, 1'b1, c[0], 1'b1);
        run_seg(CFG_3, SLOT_DOUBLE, 1'b1, 1'b0, 1'b0);
        run_seg(CFG_4B, SLOT_DOUBLE, 1'b1, 1'b1, 1'b0);
        run_seg(CFG_6, SLOT_FULL, 1'b1, 1'b1, 1'b0);
        run_seg(CFG_4A, SLOT_FULL, 1'b1, 1'b0, 1'b1);
        run_seg(CFG_2, SLOT_LONG640, 1'b1, 1'b1, 1'b0);
    endtask

    // ----------------------------------------------------------------
    // clock, reset, sequence, verdict
    // ----------------------------------------------------------------
    task automatic stop_test();
        if (errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    // about 38k cycles expected; more than twice that means a hang
    initial
    begin
        #900_000;
        errors++;
        stop_test();
    end

    initial
    begin
        {ARST_N, WR_STB, RD_STB, GO, GAP, ADDR, WR_DATA, LEN} = '0;
        {errors, checks} = '0;
        repeat (2) @(posedge MCLK);
        ARST_N <= 1'b1;
        t_regs();
        t_single();
        t_multi();
        stop_test();
    end
endmodule

// [rtl/bfield_ks_pkg.sv]
// Purpose : constants shared by the protected payload keystream mapper
// Assumes : one keystream bit and one data bit arrive per accepted beat
// Notes   : table values are data-bit counts and segment bases per slot type
package bfield_ks_pkg;

    // ----------------------------------------------------------------
    // register port map
    // ----------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFFSET    = 8'h00;  // control word
    localparam logic [7:0]  STATUS_OFFSET  = 8'h04;  // status word
    localparam int          CTRL_CFG_POS   = 0;      // 3-bit modulation config
    localparam int          CTRL_SLOT_POS  = 4;      // 3-bit slot type
    localparam int          CTRL_MULTI_POS = 8;      // 1 = multi-subfield format
    localparam int          CTRL_TAIL_POS  = 9;      // 1 = tail is encrypted control
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

    // ----------------------------------------------------------------
    // modulation configuration codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CFG_1A = 3'h0;
    localparam logic [2:0] CFG_1B = 3'h1;
    localparam logic [2:0] CFG_2  = 3'h2;
    localparam logic [2:0] CFG_3  = 3'h3;
    localparam logic [2:0] CFG_4A = 3'h4;
    localparam logic [2:0] CFG_4B = 3'h5;
    localparam logic [2:0] CFG_5  = 3'h6;
    localparam logic [2:0] CFG_6  = 3'h7;

    // ----------------------------------------------------------------
    // slot type codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SLOT_DOUBLE  = 3'h0;
    localparam logic [2:0] SLOT_FULL    = 3'h1;
    localparam logic [2:0] SLOT_HALF    = 3'h2;
    localparam logic [2:0] SLOT_LONG640 = 3'h3;
    localparam logic [2:0] SLOT_LONG672 = 3'h4;

    // ----------------------------------------------------------------
    // keystream offsets and subfield geometry
    // ----------------------------------------------------------------
    localparam logic [12:0] A_LEN_STD   = 13'h0028;  // 40 bits
    localparam logic [12:0] A_LEN_4A    = 13'h0050;  // 80 bits
    localparam logic [12:0] A_LEN_4B    = 13'h0078;  // 120 bits
    localparam logic [6:0]  SUB_WIDTH   = 7'h40;     // 64 data bits per subfield
    localparam logic [6:0]  SUB_STRIDE  = 7'h50;     // 80 keystream bits per subfield
    localparam logic [12:0] IDX_RESET   = 13'h0000;

    // raw payload bits per slot at 2-level, indexed by slot code
    localparam logic [9:0] RAW_BASE [0:4] = '{10'h320, 10'h140, 10'h050, 10'h280, 10'h2A0};
    // subfields per slot at 2-level, indexed by slot code
    localparam logic [3:0] SUB_BASE [0:4] = '{4'hA, 4'h4, 4'h1, 4'h8, 4'h8};
    // level multiplier, indexed by level 0..4
    localparam logic [2:0] LEVEL_MULT [0:4] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    // single-subfield data bits [slot][level]; half slot carries none here
    localparam logic [12:0] SINGLE_BITS [0:4][0:4] = '{
        '{13'h0300, 13'h0620, 13'h0940, 13'h0C60, 13'h12A0},
        '{13'h0130, 13'h0260, 13'h03A0, 13'h04E0, 13'h0760},
        '{13'h0000, 13'h0000, 13'h0000, 13'h0000, 13'h0000},
        '{13'h0260, 13'h04E0, 13'h0760, 13'h09E0, 13'h0EE0},
        '{13'h0280, 13'h0520, 13'h07C0, 13'h09FC, 13'h0FA0}};

endpackage

// [rtl/bfield_ks_xor.sv]
// Purpose : xor a keystream segment onto the A-field and protected payload
// Assumes : framer supplies a data bit beside every keystream bit
// Notes   : same mapping serves encrypt and decrypt
//
// Summary of operation
// - A-field handled as for unprotected payload
// - single format: payload bit i uses i+40
// - single format: 4a uses i+80, 4b i+120
// - double slot single-format data bit counts
// - full slot single-format data bit counts
// - long slot single-format data bit counts
// - multi format: 64-bit subfields, stride 80, +40
// - multi format: 4a adds 80, 4b adds 120
// - double slot subfield counts per configuration
// - full slot subfield counts per configuration
// - half slot subfield counts per configuration
// - keystream indexed from zero to length-1
// - first 40 bits hit A-field if encrypted-control tail
// - 4a/4b A-field spans 80/120 keystream bits
`timescale 1ns/10ps

module bfield_ks_xor
(
    input  wire logic        MCLK,         // system clock, 100 MHz
    input  wire logic        ARST_N,       // asynchronous reset, active low
    input  wire logic [7:0]  ADDR,         // register address
    input  wire logic [31:0] WR_DATA,      // register write data
    input  wire logic        WR_STB,       // register write strobe
    input  wire logic        RD_STB,       // register read strobe
    output logic      [31:0] RD_DATA,      // read data, cycle after strobe
    input  wire logic        START,        // segment start pulse from framer
    input  wire logic        KS_VALID,     // keystream beat valid
    input  wire logic        KS_BIT,       // keystream_segment bit
    input  wire logic        DIN_BIT,      // data bit paired with keystream bit
    output logic             OUT_VALID,    // mapped bit valid
    output logic             OUT_BIT,      // xored data bit
    output logic             OUT_FIELD_B,  // 1 = payload bit, 0 = A-field bit
    output logic             BUSY,         // segment in progress
    output logic             DONE          // last keystream bit consumed
);
    import bfield_ks_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_reg, ctrl_next;        // control word
    logic [31:0] rd_reg, rd_next;            // read data holder
    logic        busy_reg, busy_next;        // segment active
    logic        done_reg, done_next;        // end pulse
    logic [12:0] idx_reg, idx_next;          // keystream index
    logic [12:0] seg_len_reg, seg_len_next;  // keystream_segment_length
    logic [12:0] aoff_reg, aoff_next;        // A-field keystream span
    logic [12:0] nbits_reg, nbits_next;      // single-format data bits
    logic [5:0]  nsub_reg, nsub_next;        // multi-format subfield count
    logic        multi_reg, multi_next;      // latched format select
    logic        tail_reg, tail_next;        // latched tail type
    logic [6:0]  pos_reg, pos_next;          // position in 80-bit window
    logic [5:0]  sub_reg, sub_next;          // current subfield
    logic        ov_reg, ov_next;            // OUT_VALID
    logic        ob_reg, ob_next;            // OUT_BIT
    logic        of_reg, of_next;            // OUT_FIELD_B

    // ----------------------------------------------------------------
    // start-time decode
    // ----------------------------------------------------------------
    logic [2:0]  cfg;      // configuration field
    logic [2:0]  slot;     // slot type field
    logic [2:0]  slot_ix;  // slot with illegal codes folded to double
    logic [2:0]  level;    // modulation level 0..4
    logic [12:0] aoff_sel; // A-field span for configuration
    logic [12:0] raw_bits; // raw payload bits of slot

    assign cfg  = ctrl_reg[CTRL_CFG_POS +: 3];
    assign slot = ctrl_reg[CTRL_SLOT_POS +: 3];

    // level and A span from configuration
    always_comb
    begin
        slot_ix = (slot > SLOT_LONG672) ? SLOT_DOUBLE : slot;  // illegal codes fold to double
        unique case (cfg)
            CFG_1A, CFG_1B: level = 3'h0;
            CFG_2,  CFG_4A: level = 3'h1;
            CFG_3,  CFG_4B: level = 3'h2;
            CFG_5:          level = 3'h3;
            CFG_6:          level = 3'h4;
        endcase
        if (cfg == CFG_4A)
            aoff_sel = A_LEN_4A;
        else if (cfg == CFG_4B)
            aoff_sel = A_LEN_4B;
        else
            aoff_sel = A_LEN_STD;
        // operands widened first so a 4800-bit product never wraps at 10 bits
        raw_bits = 13'(RAW_BASE[slot_ix]) * 13'(LEVEL_MULT[level]);
    end

    // ----------------------------------------------------------------
    // per-beat mapping
    // ----------------------------------------------------------------
    logic        beat;     // keystream bit accepted this cycle
    logic        in_a;     // index inside A-field span
    logic [12:0] rel;      // index relative to payload start
    logic        map_b;    // payload bit mapped here

    always_comb
    begin
        beat = busy_reg && KS_VALID;
        in_a = idx_reg < aoff_reg;
        rel  = idx_reg - aoff_reg;
        if (in_a)
            map_b = 1'b0;
        else if (multi_reg)
            map_b = (pos_reg < SUB_WIDTH) && (sub_reg < nsub_reg);
        else
            map_b = rel < nbits_reg;
    end

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        ctrl_next    = ctrl_reg;
        rd_next      = 32'h0000_0000;   // unmapped reads return zero
        busy_next    = busy_reg;
        done_next    = 1'b0;
        idx_next     = idx_reg;
        seg_len_next = seg_len_reg;
        aoff_next    = aoff_reg;
        nbits_next   = nbits_reg;
        nsub_next    = nsub_reg;
        multi_next   = multi_reg;
        tail_next    = tail_reg;
        pos_next     = pos_reg;
        sub_next     = sub_reg;
        ov_next      = 1'b0;
        ob_next      = ob_reg;
        of_next      = of_reg;
        // register port
        if (WR_STB && ADDR == CTRL_OFFSET)
            ctrl_next = WR_DATA;
        if (RD_STB && ADDR == CTRL_OFFSET)
            rd_next = ctrl_reg;
        else if (RD_STB && ADDR == STATUS_OFFSET)
            rd_next = {3'h0, seg_len_reg, 2'h0, idx_reg, busy_reg};
        // segment start latches the whole selection, so tx and rx stay aligned
        if (START)
        begin
            busy_next    = 1'b1;
            idx_next     = IDX_RESET;
            aoff_next    = aoff_sel;
            seg_len_next = aoff_sel + raw_bits;
            nbits_next   = SINGLE_BITS[slot_ix][level];
            nsub_next    = 6'(SUB_BASE[slot_ix]) * 6'(LEVEL_MULT[level]);
            multi_next   = ctrl_reg[CTRL_MULTI_POS];
            tail_next    = ctrl_reg[CTRL_TAIL_POS];
            pos_next     = 7'h00;
            sub_next     = 6'h00;
        end
        else if (beat)
        begin
            // A-field bits only when tail is encrypted control
            if (in_a)
            begin
                ov_next = tail_reg;
                ob_next = KS_BIT ^ DIN_BIT;
                of_next = 1'b0;
            end
            else
            begin
                ov_next = map_b;
                ob_next = KS_BIT ^ DIN_BIT;
                of_next = 1'b1;
                // 80-bit window walk; last 16 bits of each are gaps
                if (pos_reg == SUB_STRIDE - 7'h01)
                begin
                    pos_next = 7'h00;
                    sub_next = sub_reg + 6'h01;
                end
                else
                    pos_next = pos_reg + 7'h01;
            end
            idx_next = idx_reg + 13'h0001;
            if (idx_reg == seg_len_reg - 13'h0001)
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            ctrl_reg    <= CTRL_RESET;
            rd_reg      <= 32'h0000_0000;
            busy_reg    <= 1'b0;
            done_reg    <= 1'b0;
            idx_reg     <= IDX_RESET;
            seg_len_reg <= IDX_RESET;
            aoff_reg    <= A_LEN_STD;
            nbits_reg   <= IDX_RESET;
            nsub_reg    <= 6'h00;
            multi_reg   <= 1'b0;
            tail_reg    <= 1'b0;
            pos_reg     <= 7'h00;
            sub_reg     <= 6'h00;
            ov_reg      <= 1'b0;
            ob_reg      <= 1'b0;
            of_reg      <= 1'b0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            rd_reg      <= rd_next;
            busy_reg    <= busy_next;
            done_reg    <= done_next;
            idx_reg     <= idx_next;
            seg_len_reg <= seg_len_next;
            aoff_reg    <= aoff_next;
            nbits_reg   <= nbits_next;
            nsub_reg    <= nsub_next;
            multi_reg   <= multi_next;
            tail_reg    <= tail_next;
            pos_reg     <= pos_next;
            sub_reg     <= sub_next;
            ov_reg      <= ov_next;
            ob_reg      <= ob_next;
            of_reg      <= of_next;
        end
    end

    assign RD_DATA     = rd_reg;
    assign OUT_VALID   = ov_reg;
    assign OUT_BIT     = ob_reg;
    assign OUT_FIELD_B = of_reg;
    assign BUSY        = busy_reg;
    assign DONE        = done_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);

    // mapping and segment-end checks one cycle after the accepted beat; 4a/4b offsets and double slot sizing one cycle after start
    AST_A_DISCARD: assert property (
        beat && !START && in_a && !tail_reg |=> !OUT_VALID)
        else $error("A-field bit emitted with plain tail");
    AST_A_XOR: assert property (
        beat && !START && in_a && tail_reg |=> OUT_VALID && !OUT_FIELD_B && OUT_BIT == $past(KS_BIT ^ DIN_BIT))
        else $error("A-field bit not xored");
    AST_SINGLE_XOR: assert property (
        beat && !START && !multi_reg && !in_a && rel < nbits_reg
        |=> OUT_VALID && OUT_FIELD_B && OUT_BIT == $past(KS_BIT ^ DIN_BIT))
        else $error("single payload bit not xored");
    AST_SINGLE_END: assert property (
        beat && !START && !multi_reg && !in_a && rel >= nbits_reg |=> !OUT_VALID)
        else $error("payload bit emitted past data length");
    AST_MULTI_GAP: assert property (
        beat && !START && multi_reg && !in_a && pos_reg >= SUB_WIDTH |=> !OUT_VALID)
        else $error("gap keystream bit used");
    AST_MULTI_COUNT: assert property (
        beat && !START && multi_reg && !in_a && sub_reg >= nsub_reg |=> !OUT_VALID)
        else $error("subfield beyond count emitted");
    AST_OFF_4A: assert property (
        START && cfg == CFG_4A |=> aoff_reg == 13'h0050)
        else $error("4a offset wrong");
    AST_OFF_4B: assert property (
        START && cfg == CFG_4B |=> aoff_reg == 13'h0078)
        else $error("4b offset wrong");
    AST_SEG_END: assert property (
        beat && !START && idx_reg == seg_len_reg - 13'h0001 |=> DONE && !BUSY ##1 !DONE)
        else $error("segment end mishandled");
    AST_LEN_D6: assert property (
        START && cfg == CFG_6 && slot == SLOT_DOUBLE |=> seg_len_reg == 13'h12E8 && nbits_reg == 13'h12A0)
        else $error("double slot config 6 sizing wrong");
    // sizing and offsets latched at start; no output while idle
    AST_OFF_STD: assert property (
        START && cfg != CFG_4A && cfg != CFG_4B |=> aoff_reg == 13'h0028)
        else $error("standard offset wrong");
    AST_LEN_F1: assert property (
        START && cfg == CFG_1A && slot == SLOT_FULL |=> seg_len_reg == 13'h0168 && nbits_reg == 13'h0130)
        else $error("full slot config 1a sizing wrong");
    AST_NSUB_H6: assert property (
        START && cfg == CFG_6 && slot == SLOT_HALF |=> nsub_reg == 6'h06)
        else $error("half slot config 6 subfield count wrong");
    AST_IDLE_QUIET: assert property (
        !busy_reg && !START |=> !OUT_VALID)
        else $error("output bit while no segment active");

    // main scenarios: both formats, A-field bits, stalled stream
    COV_SINGLE: cover property (START && !ctrl_reg[CTRL_MULTI_POS] ##[1:1000] DONE);
    COV_MULTI: cover property (START && ctrl_reg[CTRL_MULTI_POS] ##[1:1000] DONE);
    COV_A_XOR: cover property (OUT_VALID && !OUT_FIELD_B);
    COV_STALL: cover property (BUSY && !KS_VALID ##1 OUT_VALID);

endmodule
